// ===== common/bwsc_pkg.sv
// Package: constants and types for the bus wait-state controller
package bwsc_pkg;

  // Register map (byte address of the flyby wait register)
  localparam logic [31:0] BWSC_FLYBY_WAIT_ADDR  = 32'hfffff494;
  localparam logic [15:0] BWSC_FLYBY_WAIT_RESET = 16'h7777;
  localparam logic [15:0] BWSC_FLYBY_WAIT_MASK  = 16'h7777;
  localparam logic [1:0]  BWSC_FULL_HALFWORD    = 2'h3;

  // Field layout
  localparam int BWSC_CHANNELS    = 4;
  localparam int BWSC_FIELD_W     = 3;
  localparam int BWSC_FIELD_PITCH = 4;
  localparam int BWSC_CNT_W       = 4;

  // Access area of a bus cycle
  typedef enum logic [1:0] {
    BWSC_AREA_EXTERNAL = 2'h0,
    BWSC_AREA_IRAM     = 2'h1,
    BWSC_AREA_DRAM     = 2'h2,
    BWSC_AREA_PERIPH   = 2'h3
  } bwsc_area_e;

  // Memory type configured for the addressed block
  typedef enum logic [1:0] {
    BWSC_MEM_SRAM     = 2'h0,
    BWSC_MEM_PAGE_ROM = 2'h1,
    BWSC_MEM_SDRAM    = 2'h2,
    BWSC_MEM_NONE     = 2'h3
  } bwsc_mem_e;

  // Bus states, Gray coded along idle-setup-first-wait-last
  typedef enum logic [2:0] {
    BWSC_ST_IDLE  = 3'h0,
    BWSC_ST_SETUP = 3'h1,
    BWSC_ST_FIRST = 3'h3,
    BWSC_ST_WAIT  = 3'h2,
    BWSC_ST_LAST  = 3'h6
  } bwsc_state_e;

  // Bus cycle request
  typedef struct packed {
    bwsc_area_e  area;
    bwsc_mem_e   mem_type;
    logic        flyby;
    logic [1:0]  channel;
    logic        on_page;
    logic [1:0]  setup_count;
    logic [2:0]  space_data_wait;
    logic [2:0]  page_wait;
  } bwsc_req_s;

  // Register port write
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
    logic [1:0]  lanes;
  } bwsc_reg_s;

endpackage : bwsc_pkg

// ===== hw/bwsc_wait_ctrl.sv
// Bus wait-state controller: programmable and external wait combination
`timescale 1ns/1ps
module bwsc_wait_ctrl
  import bwsc_pkg::*;
#(
  parameter int CHANNELS = BWSC_CHANNELS
) (
  // Clock, reset, enable
  input  wire logic         clk_sys_in,
  input  wire logic         reset_in,
  input  wire logic         ce_in,
  // Register port
  input  wire logic [31:0]  reg_addr_in,
  input  wire logic [15:0]  reg_wdata_in,
  input  wire logic [1:0]   reg_lanes_in,
  input  wire logic         reg_write_in,
  input  wire logic         reg_read_in,
  output logic      [15:0]  reg_rdata_out,
  // Bus cycle request from the bus sequencer
  input  wire logic         cycle_start_in,
  input  wire bwsc_req_s    cycle_req_in,
  input  wire logic         periph_wait_in,
  // External wait pin, active low, asynchronous
  input  wire logic         ext_wait_n_in,
  // Bus state outputs
  output bwsc_state_e       bus_state_out,
  output logic              wait_state_out,
  output logic              cycle_done_out,
  output logic              busy_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check

  if (CHANNELS != BWSC_CHANNELS) begin : g_chk
    $error("bwsc_wait_ctrl: channel count must match register layout");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flyby wait register

  logic [15:0] flyby_data_wait_control;
  bwsc_reg_s   reg_bus;
  logic        reg_hit;
  logic        reg_full;
  logic        reg_wr_ok;
  logic        reg_rd_ok;
  logic [15:0] next_rdata;

  assign reg_bus    = '{addr: reg_addr_in, data: reg_wdata_in, lanes: reg_lanes_in};
  assign reg_hit    = (reg_bus.addr == BWSC_FLYBY_WAIT_ADDR);
  assign reg_full   = (reg_bus.lanes == BWSC_FULL_HALFWORD);
  assign reg_wr_ok  = reg_write_in && reg_hit && reg_full;
  assign reg_rd_ok  = reg_read_in && reg_hit && reg_full;
  assign next_rdata = reg_rd_ok ? (flyby_data_wait_control & BWSC_FLYBY_WAIT_MASK) : 16'h0000;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      flyby_data_wait_control <= BWSC_FLYBY_WAIT_RESET;
      reg_rdata_out           <= 16'h0000;
    end else if (ce_in) begin
      if (reg_wr_ok) begin
        flyby_data_wait_control <= reg_bus.data & BWSC_FLYBY_WAIT_MASK;
      end
      reg_rdata_out <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel field extraction

  logic [BWSC_FIELD_W-1:0] channel_flyby_wait_count [CHANNELS];

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_field
    assign channel_flyby_wait_count[ch] =
      flyby_data_wait_control[ch*BWSC_FIELD_PITCH +: BWSC_FIELD_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // External wait synchroniser

  logic ext_wait_meta;
  logic ext_wait_sync_n;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ext_wait_meta   <= 1'b1;
      ext_wait_sync_n <= 1'b1;
    end else if (ce_in) begin
      ext_wait_meta   <= ext_wait_n_in;
      ext_wait_sync_n <= ext_wait_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wait count selection

  logic                  req_internal;
  logic                  req_periph;
  logic                  req_sdram;
  logic [BWSC_CNT_W-1:0] flyby_count;
  logic [BWSC_CNT_W-1:0] space_count;
  logic [BWSC_CNT_W-1:0] prog_count;
  logic [2:0]            flyby_field;

  assign req_internal = (cycle_req_in.area == BWSC_AREA_IRAM)
                     || (cycle_req_in.area == BWSC_AREA_DRAM);
  assign req_periph   = (cycle_req_in.area == BWSC_AREA_PERIPH);
  assign req_sdram    = (cycle_req_in.mem_type == BWSC_MEM_SDRAM);
  assign flyby_field  = channel_flyby_wait_count[cycle_req_in.channel];
  assign flyby_count  = req_sdram ? ({1'b0, flyby_field} + 4'h1)
                                  : {1'b0, flyby_field};
  assign space_count  = (cycle_req_in.mem_type == BWSC_MEM_PAGE_ROM && cycle_req_in.on_page)
                      ? {1'b0, cycle_req_in.page_wait}
                      : (req_sdram ? 4'h0 : {1'b0, cycle_req_in.space_data_wait});
  assign prog_count   = (req_internal || req_periph) ? 4'h0
                      : (cycle_req_in.flyby ? flyby_count : space_count);

  ////////////////////////////////////////////////////////////////////////////
  // Cycle attributes held for the whole cycle, wait and setup down-counters and bus state

  logic                  hold_ext_ok;
  logic                  hold_periph;
  logic [BWSC_CNT_W-1:0] wait_left;
  logic [1:0]            setup_left;
  bwsc_state_e           state;

  ////////////////////////////////////////////////////////////////////////////
  // Next state and wait decision

  bwsc_state_e           next_state;
  logic [BWSC_CNT_W-1:0] next_wait_left;
  logic [1:0]            next_setup_left;
  logic                  ext_req;
  logic                  periph_req;
  logic                  prog_req;
  logic                  more_wait;
  logic                  start_ok;
  logic                  start_setup;

  assign ext_req     = hold_ext_ok && !ext_wait_sync_n;
  assign periph_req  = hold_periph && periph_wait_in;
  assign prog_req    = (wait_left != 4'h0);
  assign more_wait   = prog_req || ext_req || periph_req;
  assign start_ok    = cycle_start_in && (state == BWSC_ST_IDLE || state == BWSC_ST_LAST);
  assign start_setup = (cycle_req_in.setup_count != 2'h0) && !req_internal && !req_periph
                    && !req_sdram;

  always_comb begin
    next_state      = state;
    next_wait_left  = wait_left;
    next_setup_left = setup_left;
    unique case (state)
      BWSC_ST_IDLE, BWSC_ST_LAST: begin
        next_state = BWSC_ST_IDLE;
        if (start_ok) begin
          next_wait_left  = prog_count;
          next_setup_left = cycle_req_in.setup_count;
          next_state      = start_setup ? BWSC_ST_SETUP : BWSC_ST_FIRST;
        end
      end
      BWSC_ST_SETUP: begin
        next_setup_left = setup_left - 2'h1;
        if (setup_left == 2'h1) begin
          next_state = BWSC_ST_FIRST;
        end
      end
      BWSC_ST_FIRST, BWSC_ST_WAIT: begin
        next_state = more_wait ? BWSC_ST_WAIT : BWSC_ST_LAST;
        if (prog_req) begin
          next_wait_left = wait_left - 4'h1;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state       <= BWSC_ST_IDLE;
      wait_left   <= 4'h0;
      setup_left  <= 2'h0;
      hold_ext_ok <= 1'b0;
      hold_periph <= 1'b0;
    end else if (ce_in) begin
      state      <= next_state;
      wait_left  <= next_wait_left;
      setup_left <= next_setup_left;
      if (start_ok) begin
        hold_ext_ok <= !req_internal && !req_periph && !req_sdram;
        hold_periph <= req_periph;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      bus_state_out  <= BWSC_ST_IDLE;
      wait_state_out <= 1'b0;
      cycle_done_out <= 1'b0;
      busy_out       <= 1'b0;
    end else if (ce_in) begin
      bus_state_out  <= next_state;
      wait_state_out <= (next_state == BWSC_ST_WAIT);
      cycle_done_out <= (next_state == BWSC_ST_LAST);
      busy_out       <= (next_state != BWSC_ST_IDLE);
    end
  end

endmodule : bwsc_wait_ctrl

// ===== tb/bwsc_ext_dev.sv
// Partner: slow external device holding the wait pin low
`timescale 1ns/1ps
module bwsc_ext_dev (
  // Clock and cycle activity
  input  wire logic       clk_sys_in,
  input  wire logic       busy_in,
  input  wire logic [7:0] hold_in,
  // Wait pin, pulled high when released
  output logic            ext_wait_n_out
);
  logic [7:0] left = 8'h0;
  always @(posedge clk_sys_in) begin
    if (!busy_in) left <= hold_in;
    else if (left != 8'h0) left <= left - 8'h1;
  end
  assign ext_wait_n_out = !(busy_in && left != 8'h0);
endmodule : bwsc_ext_dev

// ===== tb/bwsc_wait_ctrl_sva.sv
// Checker: wait-state controller port assertions
`timescale 1ns/1ps
module bwsc_wait_ctrl_chk
  import bwsc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys_in, reset_in, ce_in,
  // Register port
  input wire logic [31:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in, reg_rdata_out,
  input wire logic [1:0]  reg_lanes_in,
  input wire logic        reg_write_in, reg_read_in,
  // Bus cycle
  input wire logic        cycle_start_in, periph_wait_in, ext_wait_n_in,
  input wire bwsc_req_s   cycle_req_in,
  input wire bwsc_state_e bus_state_out,
  input wire logic        wait_state_out, cycle_done_out, busy_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  wire  take = ce_in && cycle_start_in && bus_state_out inside {BWSC_ST_IDLE, BWSC_ST_LAST};
  wire  is_ext = cycle_req_in.area == BWSC_AREA_EXTERNAL;
  wire  ext_req = is_ext && cycle_req_in.mem_type != BWSC_MEM_SDRAM;
  logic ext_cyc;
  // Pin-driven cycle of the current transfer
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) ext_cyc <= 1'b0;
    else if (take) ext_cyc <= ext_req;
  end
  a_gap_bits_zero: assert property ((reg_rdata_out & ~BWSC_FLYBY_WAIT_MASK) == 16'h0)
    else $error("flyby register gap bit set");
  a_rdata_idle_zero: assert property (ce_in && !reg_read_in |=> reg_rdata_out == 16'h0)
    else $error("read data outside read slot");
  a_part_read_zero: assert property (ce_in && reg_read_in
    && reg_lanes_in != BWSC_FULL_HALFWORD
    |=> reg_rdata_out == 16'h0) else $error("partial read returned data");
  a_iram_no_wait: assert property (take && cycle_req_in.area inside {BWSC_AREA_IRAM,
    BWSC_AREA_DRAM} |=> bus_state_out == BWSC_ST_FIRST ##1 bus_state_out == BWSC_ST_LAST)
    else $error("internal RAM cycle got waits");
  a_periph_own_wait: assert property (take && cycle_req_in.area == BWSC_AREA_PERIPH
    |=> bus_state_out == BWSC_ST_FIRST ##1
    bus_state_out == ($past(periph_wait_in) ? BWSC_ST_WAIT : BWSC_ST_LAST))
    else $error("peripheral cycle wait mismatch");
  a_pin_stretch: assert property (bus_state_out inside {BWSC_ST_FIRST, BWSC_ST_WAIT}
    && ext_cyc && !$past(ext_wait_n_in, 2) |=> bus_state_out == BWSC_ST_WAIT)
    else $error("low wait pin did not stretch cycle");
  a_sdram_fly_wait: assert property (take && is_ext && cycle_req_in.flyby
    && cycle_req_in.mem_type == BWSC_MEM_SDRAM |=> bus_state_out == BWSC_ST_FIRST ##1
    bus_state_out == BWSC_ST_WAIT) else $error("sdram flyby without wait");
  a_setup_len_two: assert property (take && ext_req && cycle_req_in.setup_count == 2'h2
    |=> bus_state_out == BWSC_ST_SETUP [*2] ##1 bus_state_out == BWSC_ST_FIRST)
    else $error("setup length wrong");
  c_flyby: cover property (take && cycle_req_in.flyby);
  c_pin_wait: cover property (wait_state_out && ext_cyc);
  c_reg_read: cover property (reg_read_in && reg_addr_in == BWSC_FLYBY_WAIT_ADDR);
endmodule : bwsc_wait_ctrl_chk
////////////////////////////////////////////////////////////////////////////////
bind bwsc_wait_ctrl bwsc_wait_ctrl_chk i_chk (.*);

// ===== tb/bwsc_wait_ctrl_tb.sv
// Testbench: wait-state controller register and bus cycle scenarios
`timescale 1ns/1ps
module bwsc_wait_ctrl_tb
  import bwsc_pkg::*;
;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, ce_in = 1'b1;
  logic [31:0] reg_addr_in = 32'h0;
  logic [15:0] reg_wdata_in = 16'h0, reg_rdata_out;
  logic [1:0] reg_lanes_in = 2'h0;
  logic reg_write_in = 1'b0, reg_read_in = 1'b0, cycle_start_in = 1'b0, periph_wait_in = 1'b0;
  bwsc_req_s cycle_req_in = '0;
  logic [7:0] hold_len = 8'h0;
  wire logic ext_wait_n_in;
  bwsc_state_e bus_state_out;
  logic wait_state_out, cycle_done_out, busy_out;
  int miscompares = 0, check_count = 0, nw, ns;
  always #12.5 clk_sys_in = ~clk_sys_in;
  bwsc_wait_ctrl i_dut (.*);
  bwsc_ext_dev i_dev (.clk_sys_in(clk_sys_in), .busy_in(busy_out), .hold_in(hold_len),
    .ext_wait_n_out(ext_wait_n_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [31:0] a, input logic [1:0] ln,
                     input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_lanes_in <= ln;
    reg_wdata_in <= d;
    reg_write_in <= wr;
    reg_read_in <= !wr;
    @(posedge clk_sys_in);
    reg_write_in <= 1'b0;
    reg_read_in <= 1'b0;
    #1;
    if (!wr) chk("register read", d, reg_rdata_out);
  endtask : acc
  task automatic run(input bwsc_area_e ar, input bwsc_mem_e mt, input logic fly,
                     input logic [1:0] ch, input logic [1:0] su, input logic [2:0] dw,
                     input logic [7:0] hl);
    int i;
    nw = 0;
    ns = 0;
    @(posedge clk_sys_in);
    hold_len <= hl;
    @(posedge clk_sys_in);
    cycle_start_in <= 1'b1;
    cycle_req_in <= '{ar, mt, fly, ch, 1'b1, su, dw, 3'h2};
    @(posedge clk_sys_in);
    cycle_start_in <= 1'b0;
    for (i = 0; i < 64; i++) begin
      #1;
      if (bus_state_out === BWSC_ST_LAST) break;
      nw += int'(bus_state_out === BWSC_ST_WAIT);
      ns += int'(bus_state_out === BWSC_ST_SETUP);
      @(posedge clk_sys_in);
    end
    if (i == 64) begin
      miscompares++;
      close_out();
    end
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    acc(1'b0, BWSC_FLYBY_WAIT_ADDR, 2'h3, BWSC_FLYBY_WAIT_RESET);
    acc(1'b1, BWSC_FLYBY_WAIT_ADDR, 2'h1, 16'h1111);
    acc(1'b0, BWSC_FLYBY_WAIT_ADDR, 2'h2, 16'h0);
    acc(1'b1, BWSC_FLYBY_WAIT_ADDR + 32'h4, 2'h3, 16'h0);
    acc(1'b0, BWSC_FLYBY_WAIT_ADDR + 32'h4, 2'h3, 16'h0);
    acc(1'b0, BWSC_FLYBY_WAIT_ADDR, 2'h3, 16'h7777);
    acc(1'b1, BWSC_FLYBY_WAIT_ADDR, 2'h3, 16'hf538);
    acc(1'b0, BWSC_FLYBY_WAIT_ADDR, 2'h3, 16'h7530);
  endtask : t_regs
  task automatic t_flyby;
    logic [15:0] k;
    for (int c = 0; c < 4; c++) begin
      k = (16'h7530 >> (4 * c)) & 16'h7;
      run(BWSC_AREA_EXTERNAL, BWSC_MEM_SRAM, 1'b1, 2'(c), 2'h0, 3'h6, 8'h0);
      chk("flyby waits", k, 16'(nw));
      run(BWSC_AREA_EXTERNAL, BWSC_MEM_SDRAM, 1'b1, 2'(c), 2'h0, 3'h6, 8'h9);
      chk("sdram flyby waits", k + 16'h1, 16'(nw));
    end
  endtask : t_flyby
  task automatic t_areas;
    bwsc_area_e ar[3] = '{BWSC_AREA_IRAM, BWSC_AREA_DRAM, BWSC_AREA_PERIPH};
    foreach (ar[j]) begin
      run(ar[j], BWSC_MEM_SRAM, 1'b0, 2'h0, 2'h3, 3'h7, 8'h20);
      chk("internal states", 16'h0, 16'(nw + ns));
    end
    run(BWSC_AREA_EXTERNAL, BWSC_MEM_SRAM, 1'b0, 2'h0, 2'h2, 3'h1, 8'h18);
    chk("setup states", 16'h2, 16'(ns));
    chk("stretched waits", 16'h1, 16'(nw >= 18 && nw <= 30));
    run(BWSC_AREA_EXTERNAL, BWSC_MEM_SRAM, 1'b0, 2'h0, 2'h0, 3'h4, 8'h0);
    chk("sram waits", 16'h4, 16'(nw));
    run(BWSC_AREA_EXTERNAL, BWSC_MEM_PAGE_ROM, 1'b0, 2'h0, 2'h0, 3'h6, 8'h0);
    chk("page waits", 16'h2, 16'(nw));
    run(BWSC_AREA_EXTERNAL, BWSC_MEM_SDRAM, 1'b0, 2'h0, 2'h0, 3'h5, 8'h9);
    chk("sdram waits", 16'h0, 16'(nw));
  endtask : t_areas
  task automatic t_periph;
    int i;
    int w;
    w = 0;
    @(posedge clk_sys_in);
    periph_wait_in <= 1'b1;
    cycle_start_in <= 1'b1;
    cycle_req_in <= '{BWSC_AREA_PERIPH, BWSC_MEM_SRAM, 1'b0, 2'h0, 1'b0, 2'h0, 3'h7, 3'h7};
    @(posedge clk_sys_in);
    cycle_start_in <= 1'b0;
    for (i = 0; i < 16; i++) begin
      #1;
      if (cycle_done_out === 1'b1) break;
      w += int'(wait_state_out === 1'b1);
      @(posedge clk_sys_in);
      if (i == 1) periph_wait_in <= 1'b0;
    end
    if (i == 16) begin
      miscompares++;
      close_out();
    end
    chk("peripheral waits", 16'h2, 16'(w));
    @(posedge clk_sys_in);
    #1;
    chk("busy after cycle", 16'h0, {15'h0, busy_out});
  endtask : t_periph
  initial begin
    repeat (16) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    t_regs();
    t_flyby();
    t_areas();
    t_periph();
    close_out();
  end
endmodule : bwsc_wait_ctrl_tb
